// [acis_ctrl.sv]
// Purpose: Conversion clock, auto sample timing and input selection
// Assumes: Converter core pulses conv_done once per conversion
// Notes:   rc_clk_in is asynchronous and passes a two-stage synchroniser
`default_nettype none

module acis_ctrl #(
    parameter bit SECOND_INSTANCE = 1'b0
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Converter core handshake
    input  wire logic        rc_clk_in,
    input  wire logic        sample_start,
    input  wire logic        sample_end,
    input  wire logic        conv_done,
    output logic             sampling,
    output logic             conv_start,
    output logic             conv_clk_tick,
    // Input selection towards the analog mux
    output logic             use_sample_b,
    output logic             twelve_bit_mode,
    output logic      [4:0]  ch0_pos_input,
    output logic             ch0_neg_an1,
    output logic             ch123_enable,
    output logic      [4:0]  ch123_pos_base,
    output logic      [4:0]  ch123_neg_base,
    output logic             ch123_neg_ref,
    // DMA channel
    output logic      [7:0]  dma_words_per_input
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] dma_words(input logic [2:0] code);
        dma_words = 8'h01 << code;
    endfunction

    function automatic logic [15:0] masked(input logic [15:0] v,
                                           input logic [15:0] m);
        masked = v & m;
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0] clk_ctrl_reg;
    logic [15:0] dma_len_reg;
    logic [15:0] ch123_reg;
    logic [15:0] ch0_reg;
    logic [15:0] mode_reg;
    logic [15:0] ch0_wr_next;

    acis_pkg::acis_state_t state_reg;
    acis_pkg::acis_state_t state_next;

    logic        conv_clock_source_sel;
    logic [4:0]  auto_sample_time;
    logic [7:0]  conv_clock_divider;
    logic        resolution_mode;
    logic [2:0]  sample_trigger_source;
    logic        alternate_input_mode;
    logic        auto_mode;

    assign conv_clock_source_sel = clk_ctrl_reg[acis_pkg::CLK_SRC_BIT];
    assign auto_sample_time      = clk_ctrl_reg[acis_pkg::SAMC_LSB +: 5];
    assign conv_clock_divider    = clk_ctrl_reg[7:0];
    assign resolution_mode       = mode_reg[acis_pkg::RES_MODE_BIT];
    assign sample_trigger_source = mode_reg[acis_pkg::TRIG_LSB +: 3];
    assign alternate_input_mode  = mode_reg[acis_pkg::ALT_BIT];
    assign auto_mode = (sample_trigger_source == acis_pkg::TRIG_AUTO);

    // Second instance has no upper sixteen inputs
    always_comb begin
        ch0_wr_next = masked(reg_wdata, acis_pkg::MASK_CH0);
        if (SECOND_INSTANCE) begin
            ch0_wr_next[4] = 1'b0;
            ch0_wr_next[acis_pkg::CH0_B_LSB + 4] = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clk_ctrl_reg <= acis_pkg::REG_RESET;
            dma_len_reg  <= acis_pkg::REG_RESET;
            ch123_reg    <= acis_pkg::REG_RESET;
            ch0_reg      <= acis_pkg::REG_RESET;
            mode_reg     <= acis_pkg::REG_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                acis_pkg::OFS_CLK_CTRL:
                    clk_ctrl_reg <= masked(reg_wdata, acis_pkg::MASK_CLK_CTRL);
                acis_pkg::OFS_DMA_LEN:
                    dma_len_reg <= masked(reg_wdata, acis_pkg::MASK_DMA_LEN);
                acis_pkg::OFS_CH123:
                    ch123_reg <= masked(reg_wdata, acis_pkg::MASK_CH123);
                acis_pkg::OFS_CH0:
                    ch0_reg <= ch0_wr_next;
                acis_pkg::OFS_MODE:
                    mode_reg <= masked(reg_wdata, acis_pkg::MASK_MODE);
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read port, data valid only in the cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                acis_pkg::OFS_CLK_CTRL: reg_rdata <= clk_ctrl_reg;
                acis_pkg::OFS_DMA_LEN:  reg_rdata <= dma_len_reg;
                acis_pkg::OFS_CH123:
                    reg_rdata <= resolution_mode ? 16'h0000 : ch123_reg;
                acis_pkg::OFS_CH0:      reg_rdata <= ch0_reg;
                acis_pkg::OFS_MODE:     reg_rdata <= mode_reg;
                acis_pkg::OFS_STATUS:
                    reg_rdata <= {13'h0000, use_sample_b,
                                  state_reg == acis_pkg::ACIS_CONVERT,
                                  state_reg == acis_pkg::ACIS_SAMPLE};
                default:                reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // Conversion clock
    // ------------------------------------------------------------
    logic       rc_sync1_reg;
    logic       rc_sync2_reg;
    logic       rc_prev_reg;
    logic       rc_rise;
    logic [7:0] div_cnt_reg;
    logic [7:0] div_lim;
    logic       div_hit;
    logic       clk_wr;

    // Reserved divider codes clamp to the longest legal period
    assign div_lim = (conv_clock_divider > acis_pkg::DIV_MAX) ?
                     acis_pkg::DIV_MAX : conv_clock_divider;
    assign div_hit = (div_cnt_reg == div_lim);
    assign rc_rise = rc_sync2_reg & ~rc_prev_reg;
    assign clk_wr  = reg_wr && (reg_addr == acis_pkg::OFS_CLK_CTRL);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rc_sync1_reg <= 1'b0;
            rc_sync2_reg <= 1'b0;
            rc_prev_reg  <= 1'b0;
        end else begin
            rc_sync1_reg <= rc_clk_in;
            rc_sync2_reg <= rc_sync1_reg;
            rc_prev_reg  <= rc_sync2_reg;
        end
    end

    // Restart on write so a new period starts cleanly
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_cnt_reg <= 8'h00;
        end else if (clk_wr || div_hit) begin
            div_cnt_reg <= 8'h00;
        end else begin
            div_cnt_reg <= div_cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            conv_clk_tick <= 1'b0;
        end else begin
            conv_clk_tick <= conv_clock_source_sel ? rc_rise
                                                   : div_hit;
        end
    end

    // ------------------------------------------------------------
    // Sample and convert sequencing
    // ------------------------------------------------------------
    logic [4:0] samp_cnt_reg;
    logic       end_now;

    // Auto mode ignores the external end strobe
    assign end_now = auto_mode ? (samp_cnt_reg == auto_sample_time)
                               : sample_end;
    assign sampling = (state_reg == acis_pkg::ACIS_SAMPLE);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            acis_pkg::ACIS_IDLE:
                if (sample_start) state_next = acis_pkg::ACIS_SAMPLE;
            acis_pkg::ACIS_SAMPLE:
                if (end_now) state_next = acis_pkg::ACIS_CONVERT;
            acis_pkg::ACIS_CONVERT:
                if (conv_done) state_next = acis_pkg::ACIS_IDLE;
            default:
                state_next = acis_pkg::ACIS_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= acis_pkg::ACIS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            samp_cnt_reg <= 5'h00;
        end else if (state_reg != acis_pkg::ACIS_SAMPLE) begin
            samp_cnt_reg <= 5'h00;
        end else if (conv_clk_tick && !end_now) begin
            samp_cnt_reg <= samp_cnt_reg + 5'h01;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            conv_start <= 1'b0;
        end else begin
            conv_start <= sampling && end_now;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            use_sample_b <= 1'b0;
        end else if (!alternate_input_mode) begin
            use_sample_b <= 1'b0;
        end else if (state_reg == acis_pkg::ACIS_CONVERT && conv_done) begin
            use_sample_b <= ~use_sample_b;
        end
    end

    // ------------------------------------------------------------
    // Input selection outputs
    // ------------------------------------------------------------
    logic [4:0] ch0_pos_sel_a;
    logic [4:0] ch0_pos_sel_b;
    logic       ch_zero_neg_sel_a;
    logic       ch_zero_neg_sel_b;
    logic       ch1to3_pos_sel_a;
    logic       ch1to3_pos_sel_b;
    logic [1:0] ch1to3_neg_sel_a;
    logic [1:0] ch1to3_neg_sel_b;
    logic [1:0] neg_code;

    assign ch0_pos_sel_a     = ch0_reg[4:0];
    assign ch0_pos_sel_b     = ch0_reg[acis_pkg::CH0_B_LSB +: 5];
    assign ch_zero_neg_sel_a = ch0_reg[acis_pkg::CH0_NEG_BIT];
    assign ch_zero_neg_sel_b = ch0_reg[acis_pkg::CH0_NEG_BIT + acis_pkg::CH0_B_LSB];
    assign ch1to3_pos_sel_a  = ch123_reg[0];
    assign ch1to3_pos_sel_b  = ch123_reg[acis_pkg::CH123_B_LSB];
    assign ch1to3_neg_sel_a  = ch123_reg[2:1];
    assign ch1to3_neg_sel_b  = ch123_reg[acis_pkg::CH123_B_LSB + 1 +: 2];
    assign neg_code = use_sample_b ? ch1to3_neg_sel_b : ch1to3_neg_sel_a;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ch0_pos_input       <= 5'h00;
            ch0_neg_an1         <= 1'b0;
            ch123_enable        <= 1'b0;
            ch123_pos_base      <= acis_pkg::CH123_LO;
            ch123_neg_base      <= acis_pkg::CH123_N_LO;
            ch123_neg_ref       <= 1'b1;
            twelve_bit_mode     <= 1'b0;
            dma_words_per_input <= 8'h01;
        end else begin
            ch0_pos_input   <= use_sample_b ? ch0_pos_sel_b : ch0_pos_sel_a;
            ch0_neg_an1     <= use_sample_b ? ch_zero_neg_sel_b
                                            : ch_zero_neg_sel_a;
            twelve_bit_mode <= resolution_mode;
            ch123_enable    <= !resolution_mode;
            if (resolution_mode) begin
                ch123_pos_base <= acis_pkg::CH123_LO;
                ch123_neg_ref  <= 1'b1;
                ch123_neg_base <= acis_pkg::CH123_N_LO;
            end else begin
                ch123_pos_base <= (use_sample_b ? ch1to3_pos_sel_b : ch1to3_pos_sel_a)
                                  ? acis_pkg::CH123_HI : acis_pkg::CH123_LO;
                ch123_neg_ref  <= !neg_code[1];
                ch123_neg_base <= neg_code[0] ? acis_pkg::CH123_N_HI
                                              : acis_pkg::CH123_N_LO;
            end
            dma_words_per_input <= dma_words(dma_len_reg[2:0]);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic [7:0] gap_reg;
    logic       gap_valid_reg;

    // Gap measured from tick to tick, trusted only after a full period since a write
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gap_reg       <= 8'h00;
            gap_valid_reg <= 1'b0;
        end else begin
            gap_reg       <= conv_clk_tick ? 8'h00 : gap_reg + 8'h01;
            gap_valid_reg <= !clk_wr && (gap_valid_reg || conv_clk_tick);
        end
    end

    a_div_period: assert property (@(posedge core_clk) disable iff (rst)
        (conv_clk_tick && gap_valid_reg && !conv_clock_source_sel) |->
        gap_reg == ((conv_clock_divider > acis_pkg::DIV_MAX) ? acis_pkg::DIV_MAX : conv_clock_divider))
        else $error("divided clock period wrong");

    a_tick_source: assert property (@(posedge core_clk) disable iff (rst)
        ($past(conv_clock_source_sel) && !$past(rc_rise)) |-> !conv_clk_tick)
        else $error("tick while rc clock idle");

    a_auto_end: assert property (@(posedge core_clk) disable iff (rst)
        (sampling && auto_mode && samp_cnt_reg == auto_sample_time) |=> conv_start)
        else $error("auto sample did not end");

    a_auto_hold: assert property (@(posedge core_clk) disable iff (rst)
        (sampling && auto_mode && samp_cnt_reg != auto_sample_time) |=> !conv_start)
        else $error("auto sample ended early");

    a_manual_end: assert property (@(posedge core_clk) disable iff (rst)
        (sampling && !auto_mode && sample_end) |=> conv_start ##1 !sampling)
        else $error("manual end not taken");

    a_dma_words: assert property (@(posedge core_clk) disable iff (rst)
        ##1 dma_words_per_input == (8'h01 << $past(dma_len_reg[2:0])))
        else $error("dma length decode wrong");

    a_ch123_hidden: assert property (@(posedge core_clk) disable iff (rst)
        (reg_rd && reg_addr == acis_pkg::OFS_CH123 && resolution_mode) |=> reg_rdata == 16'h0000)
        else $error("channel 1-3 select visible in 12-bit");

    a_ch0_pick: assert property (@(posedge core_clk) disable iff (rst)
        ##1 ch0_pos_input == ($past(use_sample_b) ? $past(ch0_pos_sel_b) : $past(ch0_pos_sel_a)))
        else $error("channel 0 positive select wrong");

    a_second_limit: assert property (@(posedge core_clk) disable iff (rst)
        SECOND_INSTANCE |-> !ch0_pos_input[4])
        else $error("second instance beyond AN15");

    a_alt_toggle: assert property (@(posedge core_clk) disable iff (rst)
        (alternate_input_mode && state_reg == acis_pkg::ACIS_CONVERT && conv_done)
        |=> use_sample_b != $past(use_sample_b))
        else $error("alternate sample not toggled");

    a_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
        (reg_rd && reg_addr == acis_pkg::OFS_CLK_CTRL) |=> reg_rdata[14:13] == 2'b00)
        else $error("reserved clock bits not zero");

endmodule // acis_ctrl

`default_nettype wire

// [acis_pkg.sv]
// Purpose: Constants for the converter clock and input select block
// Assumes: 16-bit registers on a plain strobe port, 4-bit word address
// Notes:   All offsets are word indices on the register port
`default_nettype none

package acis_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CLK_CTRL = 4'h0;
    localparam logic [3:0] OFS_DMA_LEN  = 4'h1;
    localparam logic [3:0] OFS_CH123    = 4'h2;
    localparam logic [3:0] OFS_CH0      = 4'h3;
    localparam logic [3:0] OFS_MODE     = 4'h4;
    localparam logic [3:0] OFS_STATUS   = 4'h5;

    // ------------------------------------------------------------
    // Writable bit masks, unimplemented bits read zero
    // ------------------------------------------------------------
    localparam logic [15:0] MASK_CLK_CTRL = 16'h9FFF;
    localparam logic [15:0] MASK_DMA_LEN  = 16'h0007;
    localparam logic [15:0] MASK_CH123    = 16'h0707;
    localparam logic [15:0] MASK_CH0      = 16'h9F9F;
    localparam logic [15:0] MASK_MODE     = 16'h04E1;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CLK_SRC_BIT   = 15;
    localparam int SAMC_LSB      = 8;
    localparam int CH123_B_LSB   = 8;
    localparam int CH0_B_LSB     = 8;
    localparam int CH0_NEG_BIT   = 7;
    localparam int RES_MODE_BIT  = 10;
    localparam int TRIG_LSB      = 5;
    localparam int ALT_BIT       = 0;

    // ------------------------------------------------------------
    // Values after reset and codes
    // ------------------------------------------------------------
    localparam logic [15:0] REG_RESET   = 16'h0000;
    localparam logic [2:0]  TRIG_AUTO   = 3'h7;
    localparam logic [7:0]  DIV_MAX     = 8'h3F;
    localparam logic [4:0]  CH123_LO    = 5'h00;
    localparam logic [4:0]  CH123_HI    = 5'h03;
    localparam logic [4:0]  CH123_N_LO  = 5'h06;
    localparam logic [4:0]  CH123_N_HI  = 5'h09;

    typedef enum logic [1:0] {
        ACIS_IDLE,
        ACIS_SAMPLE,
        ACIS_CONVERT
    } acis_state_t;

endpackage : acis_pkg

`default_nettype wire

// [acis_core_model.sv]
// Purpose: Converter core and RC oscillator on the far side of the block
// Assumes: Conversion takes DONE_DLY clocks after conv_start
// Notes:   RC oscillator runs free, unrelated in phase to core_clk
`default_nettype none

module acis_core_model #(
    parameter int DONE_DLY = 4
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // Handshake
    input  wire logic conv_start,
    output logic      conv_done,
    output logic      rc_clk_in
);
    timeunit 1ns;
    timeprecision 100ps;

    int cnt;

    // ------------------------------------------------------------
    // RC oscillator, odd period so ticks drift against core_clk
    // ------------------------------------------------------------
    initial rc_clk_in = 1'b0;
    always #87.5 rc_clk_in = ~rc_clk_in;

    // ------------------------------------------------------------
    // Conversion, one done pulse per start
    // ------------------------------------------------------------
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt       <= 0;
            conv_done <= 1'b0;
        end else begin
            conv_done <= (cnt == 1);
            if (conv_start) begin
                cnt <= DONE_DLY;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule // acis_core_model

`default_nettype wire

// [acis_ctrl_tb_top.sv]
// Purpose: Self-checking bench for the clock and input select block
// Assumes: Plain strobe register port, read data one cycle after strobe
// Notes:   Tick gaps measured between two conv_clk_tick pulses
`default_nettype none

module acis_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic core_clk, rst, reg_wr, reg_rd, sample_start, sample_end;
    logic conv_done, rc_clk_in, sampling, conv_start, conv_clk_tick;
    logic use_sample_b, twelve_bit_mode, ch0_neg_an1, ch123_enable, ch123_neg_ref;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [4:0] ch0_pos_input, ch123_pos_base, ch123_neg_base, ch0_pos2;
    logic [7:0] dma_words_per_input;
    logic [15:0] msk[4] = '{acis_pkg::MASK_CLK_CTRL, acis_pkg::MASK_DMA_LEN, acis_pkg::MASK_CH123, acis_pkg::MASK_CH0};
    logic [7:0] dv[3] = '{8'h02, 8'h3F, 8'hFF};
    int n_mismatch = 0;
    int tests_run = 0;
    int g;

    acis_ctrl i_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rc_clk_in(rc_clk_in),
        .sample_start(sample_start), .sample_end(sample_end), .conv_done(conv_done), .sampling(sampling),
        .conv_start(conv_start), .conv_clk_tick(conv_clk_tick), .use_sample_b(use_sample_b),
        .twelve_bit_mode(twelve_bit_mode), .ch0_pos_input(ch0_pos_input), .ch0_neg_an1(ch0_neg_an1),
        .ch123_enable(ch123_enable), .ch123_pos_base(ch123_pos_base), .ch123_neg_base(ch123_neg_base),
        .ch123_neg_ref(ch123_neg_ref), .dma_words_per_input(dma_words_per_input));
    acis_ctrl #(.SECOND_INSTANCE(1'b1)) i_dut2 (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(), .rc_clk_in(rc_clk_in),
        .sample_start(sample_start), .sample_end(sample_end), .conv_done(conv_done), .sampling(),
        .conv_start(), .conv_clk_tick(), .use_sample_b(), .twelve_bit_mode(), .ch0_pos_input(ch0_pos2),
        .ch0_neg_an1(), .ch123_enable(), .ch123_pos_base(), .ch123_neg_base(), .ch123_neg_ref(),
        .dma_words_per_input());
    acis_core_model i_core (.core_clk(core_clk), .rst(rst), .conv_start(conv_start),
        .conv_done(conv_done), .rc_clk_in(rc_clk_in));

    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // Bus, compare and sequencer tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge core_clk);
        reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        // Outputs are registered behind the register
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge core_clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic chk(input logic [15:0] gv, input logic [15:0] ev);
        tests_run++;
        if (gv !== ev) begin
            n_mismatch++;
            $display("FAIL %0t got %h expected %h", $time, gv, ev);
        end
    endtask
    task automatic gap(output int n);
        for (int i = 0; i < 300; i++) begin @(posedge core_clk); #1; if (conv_clk_tick === 1'b1) break; end
        for (n = 1; n < 300; n++) begin @(posedge core_clk); #1; if (conv_clk_tick === 1'b1) break; end
    endtask
    // Start a sample, optionally pulse the manual end, count cycles to conv_start
    task automatic run(input logic man, output int n);
        @(posedge core_clk);
        sample_start <= 1'b1;
        @(posedge core_clk);
        sample_start <= 1'b0;
        #1 chk(16'(sampling), 16'h0001);
        for (n = 0; n < 400; n++) begin
            @(posedge core_clk);
            sample_end <= man && (n == 0);
            #1;
            if (conv_start === 1'b1) break;
        end
        repeat (12) @(posedge core_clk);
        #1 chk(16'(sampling), 16'h0000);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1; reg_addr = 4'h0; reg_wdata = 16'h0000; reg_wr = 1'b0; reg_rd = 1'b0;
        sample_start = 1'b0; sample_end = 1'b0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
        chk(16'(dma_words_per_input), 16'h0001);
        for (int a = 0; a < 6; a++) begin rd(4'(a), d); chk(d, acis_pkg::REG_RESET); end
        for (int i = 0; i < 4; i++) begin wr(4'(i), 16'hFFFF); rd(4'(i), d); chk(d, msk[i]); end
        wr(4'hF, 16'hFFFF); rd(4'hF, d); chk(d, 16'h0000);
        wr(acis_pkg::OFS_MODE, 16'h0400); rd(acis_pkg::OFS_CH123, d); chk(d, 16'h0000);
        chk(16'(ch123_enable), 16'h0000); chk(16'(twelve_bit_mode), 16'h0001);
        wr(acis_pkg::OFS_MODE, 16'h0000); rd(acis_pkg::OFS_CH123, d); chk(d, 16'h0707);
        chk(16'(ch123_enable), 16'h0001);
        for (int c = 0; c < 8; c++) begin
            wr(acis_pkg::OFS_DMA_LEN, 16'(c)); chk(16'(dma_words_per_input), 16'(1 << c));
            wr(acis_pkg::OFS_CH123, 16'(c)); chk(16'(ch123_pos_base), c[0] ? 16'h0003 : 16'h0000);
            chk(16'(ch123_neg_ref), 16'(!c[2]));
            if (c[2]) chk(16'(ch123_neg_base), c[1] ? 16'h0009 : 16'h0006);
        end
        foreach (dv[i]) begin
            wr(acis_pkg::OFS_CLK_CTRL, {8'h00, dv[i]}); gap(g);
            chk(16'(g), (dv[i] >= 8'h40) ? 16'h0040 : 16'(dv[i]) + 16'h0001);
        end
        wr(acis_pkg::OFS_CLK_CTRL, 16'h8005); gap(g); gap(g); chk(16'(g >= 17 && g <= 18), 16'h0001);
        wr(acis_pkg::OFS_CLK_CTRL, 16'h0A00); run(1'b1, g); chk(16'(g), 16'h0001);
        wr(acis_pkg::OFS_MODE, 16'h00E0);
        wr(acis_pkg::OFS_CLK_CTRL, 16'h0000); run(1'b0, g); chk(16'(g <= 1), 16'h0001);
        wr(acis_pkg::OFS_CLK_CTRL, 16'h0A00); run(1'b1, g); chk(16'(g >= 9 && g <= 12), 16'h0001);
        wr(acis_pkg::OFS_CLK_CTRL, 16'h1F00); run(1'b0, g); chk(16'(g >= 30 && g <= 33), 16'h0001);
        wr(acis_pkg::OFS_MODE, 16'h0001);
        wr(acis_pkg::OFS_CH123, 16'h0700); wr(acis_pkg::OFS_CH0, 16'h9A1F);
        chk(16'(ch0_pos_input), 16'h001F); chk(16'(ch0_neg_an1), 16'h0000);
        chk(16'(ch0_pos2), 16'h000F);
        chk(16'(use_sample_b), 16'h0000);
        run(1'b1, g); chk(16'(use_sample_b), 16'h0001);
        chk(16'(ch0_pos_input), 16'h001A); chk(16'(ch0_neg_an1), 16'h0001);
        chk(16'(ch123_pos_base), 16'h0003); chk(16'(ch123_neg_base), 16'h0009);
        chk(16'(ch0_pos2), 16'h000A);
        rd(acis_pkg::OFS_STATUS, d); chk(d, 16'h0004);
        run(1'b1, g); chk(16'(use_sample_b), 16'h0000);
        print_verdict();
    end

    // Watchdog, well past the several hundred cycles the tests need
    initial begin
        #200000;
        n_mismatch++;
        print_verdict();
    end
endmodule // acis_ctrl_tb_top

`default_nettype wire
